// ===== core/cmmac_pkg.sv
package cmmac_pkg;

	// ----------------------------------------
	// CPU modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_BOOT = 3'h0,
		MODE_TEST = 3'h1,
		MODE_CLOS = 3'h2,
		MODE_SYSTEM = 3'h3,
		MODE_USER = 3'h4
	} cmmac_mode_type;

	localparam cmmac_mode_type RESET_MODE = MODE_SYSTEM;

	// ----------------------------------------
	// Memory spaces
	// ----------------------------------------
	typedef enum logic [1:0] {
		SPACE_ROM = 2'h0,
		SPACE_EE = 2'h1,
		SPACE_RAM = 2'h2
	} cmmac_space_type;

	// Fixed partition: addresses below the limit belong to contactless OS
	localparam logic [15:0] CLOS_ROM_LIMIT = 16'h1000;
	localparam logic [15:0] CLOS_EE_LIMIT = 16'h0800;
	localparam logic [15:0] CLOS_RAM_LIMIT = 16'h0200;

	// ----------------------------------------
	// Mode change addresses
	// ----------------------------------------
	localparam logic [15:0] SYSCALL_VEC_ADDR = 16'h0080;
	localparam logic [15:0] CONFIG_VEC_ADDR = 16'h0088;
	localparam logic [15:0] SPECIAL_CALL_ADDR = 16'h00F0;

	// ----------------------------------------
	// Register addresses and groups
	// ----------------------------------------
	localparam logic [7:0] CPU_SFR_LIMIT = 8'h90;
	localparam logic [7:0] SEG_PTR_LO_ADDR = 8'h90;
	localparam logic [7:0] SEG_PTR_HI_ADDR = 8'h91;
	localparam logic [7:0] XW_BASE_LO_ADDR = 8'h92;
	localparam logic [7:0] XW_BASE_HI_ADDR = 8'h93;
	localparam logic [7:0] XW_SIZE_ADDR = 8'h94;
	localparam logic [7:0] PROGRAM_STATUS_WORD_HIGH_ADDR = 8'h95;
	localparam logic [7:0] HW_SFR_BASE = 8'hA0;

	localparam int PROGRAM_STATUS_WORD_HIGH_MODE_LSB = 0;
	localparam int PROGRAM_STATUS_WORD_HIGH_MODE_W = 3;

	localparam logic [7:0] SEG_PTR_RESET = 8'h00;
	localparam logic [7:0] XW_BASE_RESET = 8'h00;
	localparam logic [7:0] XW_SIZE_RESET = 8'h00;
	localparam logic [7:0] PROGRAM_STATUS_WORD_HIGH_RESET = 8'h00;

endpackage

// ===== core/cmmac_mode_ctrl.sv
`timescale 1ns/1ps
module cmmac_mode_ctrl #(
	parameter int DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic excEntry,
	input wire logic retiExec,
	input wire logic fetchValid,
	input wire logic [15:0] fetchAddr,
	input wire logic callValid,
	input wire logic [15:0] callTarget,
	input wire logic pswhWr,
	input wire cmmac_pkg::cmmac_mode_type pswhMode,
	output cmmac_pkg::cmmac_mode_type mode,
	output logic stackEmpty
);
	localparam int PTR_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_FULL = PTR_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	cmmac_pkg::cmmac_mode_type mode_r;
	cmmac_pkg::cmmac_mode_type stack_r [DEPTH];
	logic [PTR_W-1:0] ptr_r;

	wire vecHit = fetchValid & (fetchAddr == cmmac_pkg::SYSCALL_VEC_ADDR ||
		fetchAddr == cmmac_pkg::CONFIG_VEC_ADDR);
	wire callHit = callValid &
		(callTarget == cmmac_pkg::SPECIAL_CALL_ADDR);
	wire enterSys = excEntry | vecHit | callHit;
	wire canPush = ptr_r != PTR_FULL;
	wire doPop = !enterSys & retiExec & (ptr_r != '0);
	wire [PTR_W-1:0] popIdx = ptr_r - PTR_ONE;

	// Full stack keeps oldest modes; return from an entry taken while full pops the newest saved mode
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_r <= cmmac_pkg::RESET_MODE;
			ptr_r <= '0;
		end else if (enterSys) begin
			mode_r <= cmmac_pkg::MODE_SYSTEM;
			if (canPush) begin
				stack_r[ptr_r[$clog2(DEPTH)-1:0]] <= mode_r;
				ptr_r <= ptr_r + PTR_ONE;
			end
		end else if (doPop) begin
			mode_r <= stack_r[popIdx[$clog2(DEPTH)-1:0]];
			ptr_r <= popIdx;
		end else if (pswhWr) begin
			mode_r <= pswhMode;
		end
	end

	assign mode = mode_r;
	assign stackEmpty = ptr_r == '0;
endmodule // cmmac_mode_ctrl

// ===== core/cmmac_mem_check.sv
`timescale 1ns/1ps
module cmmac_mem_check (
	input wire cmmac_pkg::cmmac_mode_type mode,
	input wire cmmac_pkg::cmmac_space_type memSpace,
	input wire logic [15:0] memAddr,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic memExec,
	input wire logic segActive,
	input wire logic segRdOk,
	input wire logic segWrOk,
	input wire logic segExOk,
	input wire logic [15:0] xwBase,
	input wire logic [7:0] xwSize,
	output logic memGrant
);
	logic [15:0] clLimit;
	logic opOk;
	logic userOk;

	// Boundaries are constants; nothing can move them
	assign clLimit = (memSpace == cmmac_pkg::SPACE_ROM) ?
		cmmac_pkg::CLOS_ROM_LIMIT : (memSpace == cmmac_pkg::SPACE_EE) ?
		cmmac_pkg::CLOS_EE_LIMIT : cmmac_pkg::CLOS_RAM_LIMIT;
	wire clPart = memAddr < clLimit;

	wire [16:0] xwEnd = {1'b0, xwBase} + {9'h000, xwSize};
	wire inXw = (memSpace == cmmac_pkg::SPACE_RAM) && !clPart &&
		({1'b0, memAddr} >= {1'b0, xwBase}) &&
		({1'b0, memAddr} < xwEnd);

	// ROM never written, RAM never executed
	assign opOk = (memSpace == cmmac_pkg::SPACE_ROM) ? !memWr :
		(memSpace == cmmac_pkg::SPACE_RAM) ? !memExec : 1'b1;

	// Table entries are plain memory: segment rights alone decide
	assign userOk = segActive && (!memRd || segRdOk) &&
		(!memWr || segWrOk) && (!memExec || segExOk);

	always_comb begin
		memGrant = 1'b0;
		case (mode)
			cmmac_pkg::MODE_TEST: memGrant = opOk;
			cmmac_pkg::MODE_BOOT: memGrant = opOk & clPart;
			cmmac_pkg::MODE_CLOS: memGrant = opOk & (clPart | inXw);
			cmmac_pkg::MODE_SYSTEM: memGrant = opOk & !clPart;
			cmmac_pkg::MODE_USER: memGrant = opOk & !clPart & userOk;
			default: memGrant = 1'b0;
		endcase
	end
endmodule // cmmac_mem_check

// ===== core/cmmac_top.sv
`timescale 1ns/1ps
module cmmac_top #(
	parameter int MODE_STACK_DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic reset,
	// Mode events from the core
	input wire logic excEntry,
	input wire logic retiExec,
	input wire logic fetchValid,
	input wire logic [15:0] fetchAddr,
	input wire logic callValid,
	input wire logic [15:0] callTarget,
	// Register access port
	input wire logic sfrRd,
	input wire logic sfrWr,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	output logic sfrAck,
	output logic sfrDenied,
	// Pass-through to outside register groups
	output logic extSfrRd,
	output logic extSfrWr,
	input wire logic [7:0] extSfrRdata,
	// Firewall decision for contactless OS hardware access
	input wire logic fwHwRdOk,
	input wire logic fwHwWrOk,
	// Rights of the segment holding the current code
	input wire logic segRdOk,
	input wire logic segWrOk,
	input wire logic segExOk,
	input wire logic segSfrOk,
	// Memory access port
	input wire logic memReq,
	input wire cmmac_pkg::cmmac_space_type memSpace,
	input wire logic [15:0] memAddr,
	input wire logic memRd,
	input wire logic memWr,
	input wire logic memExec,
	output logic memGrant,
	// Status
	output cmmac_pkg::cmmac_mode_type cpuMode,
	output logic [15:0] segTablePtr,
	output logic segActive
);

	// ----------------------------------------
	// Attribute registers
	// ----------------------------------------
	// Fixed set; none can be added or have its reset value altered
	logic [7:0] segPtrLo_r;
	logic [7:0] segPtrHi_r;
	logic [7:0] xwBaseLo_r;
	logic [7:0] xwBaseHi_r;
	logic [7:0] xwSize_r;
	logic [7:0] program_status_word_high_r;

	logic [7:0] sfrRdata_r;
	logic [7:0] sfrRdata_nxt;
	logic sfrAck_r;
	logic sfrDenied_r;

	cmmac_pkg::cmmac_mode_type mode;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire sfrReq = sfrRd | sfrWr;
	wire selCpu = sfrAddr < cmmac_pkg::CPU_SFR_LIMIT;
	wire selHw = sfrAddr >= cmmac_pkg::HW_SFR_BASE;
	wire selSegLo = sfrAddr == cmmac_pkg::SEG_PTR_LO_ADDR;
	wire selSegHi = sfrAddr == cmmac_pkg::SEG_PTR_HI_ADDR;
	wire selXwLo = sfrAddr == cmmac_pkg::XW_BASE_LO_ADDR;
	wire selXwHi = sfrAddr == cmmac_pkg::XW_BASE_HI_ADDR;
	wire selXwSz = sfrAddr == cmmac_pkg::XW_SIZE_ADDR;
	wire selPswh = sfrAddr == cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_ADDR;
	wire selSegCfg = selSegLo | selSegHi;
	wire selSysMgmt = selXwLo | selXwHi | selXwSz | selPswh;
	wire selExt = selCpu | selHw;
	wire selLocal = selSegCfg | selSysMgmt;

	// ----------------------------------------
	// Mode classes
	// ----------------------------------------
	// Current mode register, so each access sees any change at once
	wire isPriv = (mode == cmmac_pkg::MODE_BOOT) ||
		(mode == cmmac_pkg::MODE_TEST);
	wire isSys = mode == cmmac_pkg::MODE_SYSTEM;
	wire isClos = mode == cmmac_pkg::MODE_CLOS;
	wire isUser = mode == cmmac_pkg::MODE_USER;

	// Zero pointer means no segment is configured
	assign segActive = {segPtrHi_r, segPtrLo_r} != 16'h0000;

	// ----------------------------------------
	// Permission per group
	// ----------------------------------------
	// Segmentation setup: privileged and system only
	wire segCfgRdOk = isPriv | isSys;
	wire segCfgWrOk = isPriv | isSys;

	// Exchange window: only privileged and system modes may place it
	wire xwRdOk = isPriv | isSys;
	wire xwWrOk = isPriv | isSys;

	// Status word readable everywhere, writable only in boot, test and system modes
	wire pswhRdOk = 1'b1;
	wire pswhWrOk = isPriv | isSys;

	// Hardware group rights
	wire userHwOk = segActive & segSfrOk;
	wire hwRdOk = isPriv | isSys | (isClos & fwHwRdOk) |
		(isUser & userHwOk);
	wire hwWrOk = isPriv | isSys | (isClos & fwHwWrOk) |
		(isUser & userHwOk);

	// Denial of user and contactless access to segmentation setup
	wire segCfgDeny = selSegCfg & !segCfgWrOk;

	wire rdOk = selCpu | (selHw & hwRdOk) | (selSegCfg & segCfgRdOk) |
		((selXwLo | selXwHi | selXwSz) & xwRdOk) |
		(selPswh & pswhRdOk);
	wire wrOk = selCpu | (selHw & hwWrOk) | (selSegCfg & !segCfgDeny) |
		((selXwLo | selXwHi | selXwSz) & xwWrOk) |
		(selPswh & pswhWrOk);

	wire rdGrant = sfrRd & rdOk;
	wire wrGrant = sfrWr & wrOk;

	// ----------------------------------------
	// Mode field written through the status word
	// ----------------------------------------
	// Software may not enter boot or test mode; such mode values leave the mode unchanged
	wire [cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_MODE_W-1:0] newModeBits =
		sfrWdata[cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_MODE_LSB +: cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_MODE_W];
	wire newModeLegal =
		(newModeBits == cmmac_pkg::MODE_CLOS) ||
		(newModeBits == cmmac_pkg::MODE_SYSTEM) ||
		(newModeBits == cmmac_pkg::MODE_USER);
	wire pswhWrEn = wrGrant & selPswh;
	wire modeWr = pswhWrEn & newModeLegal;
	cmmac_pkg::cmmac_mode_type newMode;
	assign newMode = cmmac_pkg::cmmac_mode_type'(newModeBits);

	// ----------------------------------------
	// Mode tracking
	// ----------------------------------------
	cmmac_mode_ctrl #(
		.DEPTH(MODE_STACK_DEPTH)
	) u_mode (
		.ref_clk(ref_clk),
		.reset(reset),
		.excEntry(excEntry),
		.retiExec(retiExec),
		.fetchValid(fetchValid),
		.fetchAddr(fetchAddr),
		.callValid(callValid),
		.callTarget(callTarget),
		.pswhWr(modeWr),
		.pswhMode(newMode),
		.mode(mode),
		.stackEmpty()
	);

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	wire segLoWrEn = wrGrant & selSegLo;
	wire segHiWrEn = wrGrant & selSegHi;
	wire xwLoWrEn = wrGrant & selXwLo;
	wire xwHiWrEn = wrGrant & selXwHi;
	wire xwSzWrEn = wrGrant & selXwSz;

	// Reset values are constants; no input can preset them
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			segPtrLo_r <= cmmac_pkg::SEG_PTR_RESET;
			segPtrHi_r <= cmmac_pkg::SEG_PTR_RESET;
		end else begin
			if (segLoWrEn)
				segPtrLo_r <= sfrWdata;
			if (segHiWrEn)
				segPtrHi_r <= sfrWdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			xwBaseLo_r <= cmmac_pkg::XW_BASE_RESET;
			xwBaseHi_r <= cmmac_pkg::XW_BASE_RESET;
			xwSize_r <= cmmac_pkg::XW_SIZE_RESET;
		end else begin
			if (xwLoWrEn)
				xwBaseLo_r <= sfrWdata;
			if (xwHiWrEn)
				xwBaseHi_r <= sfrWdata;
			if (xwSzWrEn)
				xwSize_r <= sfrWdata;
		end
	end

	// Non-mode status bits kept here; mode bits live in the tracker
	always_ff @(posedge ref_clk) begin
		if (reset)
			program_status_word_high_r <= cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_RESET;
		else if (pswhWrEn)
			program_status_word_high_r <= sfrWdata;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] pswhView;
	always_comb begin
		pswhView = program_status_word_high_r;
		pswhView[cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_MODE_LSB +: cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_MODE_W] = mode;
	end

	wire [7:0] localRdata =
		selSegLo ? segPtrLo_r :
		selSegHi ? segPtrHi_r :
		selXwLo ? xwBaseLo_r :
		selXwHi ? xwBaseHi_r :
		selXwSz ? xwSize_r :
		selPswh ? pswhView : 8'h00;

	// Denied or unmapped reads give zero, never stale content
	always_comb begin
		sfrRdata_nxt = 8'h00;
		if (rdGrant && selLocal)
			sfrRdata_nxt = localRdata;
		else if (rdGrant && selExt)
			sfrRdata_nxt = extSfrRdata;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sfrRdata_r <= 8'h00;
			sfrAck_r <= 1'b0;
			sfrDenied_r <= 1'b0;
		end else begin
			sfrRdata_r <= sfrRdata_nxt;
			sfrAck_r <= sfrReq;
			sfrDenied_r <= (sfrRd & !rdOk) | (sfrWr & !wrOk);
		end
	end

	assign sfrRdata = sfrRdata_r;
	assign sfrAck = sfrAck_r;
	assign sfrDenied = sfrDenied_r;

	// Outside groups only see granted strobes; denied writes vanish here
	assign extSfrRd = rdGrant & selExt;
	assign extSfrWr = wrGrant & selExt;

	// ----------------------------------------
	// Memory checks
	// ----------------------------------------
	logic memOk;

	cmmac_mem_check u_mem (
		.mode(mode),
		.memSpace(memSpace),
		.memAddr(memAddr),
		.memRd(memRd),
		.memWr(memWr),
		.memExec(memExec),
		.segActive(segActive),
		.segRdOk(segRdOk),
		.segWrOk(segWrOk),
		.segExOk(segExOk),
		.xwBase({xwBaseHi_r, xwBaseLo_r}),
		.xwSize(xwSize_r),
		.memGrant(memOk)
	);

	assign memGrant = memReq & memOk;

	// ----------------------------------------
	// Status
	// ----------------------------------------
	assign cpuMode = mode;
	assign segTablePtr = {segPtrHi_r, segPtrLo_r};

endmodule // cmmac_top

// ===== verification/cmmac_sfr_model.sv
`timescale 1ns/1ps
// ----
// Outside register group
// ----
module cmmac_sfr_model (
	input wire logic ref_clk,
	input wire logic extSfrRd,
	input wire logic [7:0] sfrAddr,
	output logic [7:0] extSfrRdata
);
	logic [7:0] lastData_r = 8'hA5;
	// Idle bus shows inverse of last value, so stale data cannot pass
	assign extSfrRdata = extSfrRd ? (sfrAddr ^ 8'h5A) : ~lastData_r;
	always_ff @(posedge ref_clk) begin
		lastData_r <= extSfrRdata;
	end
endmodule // cmmac_sfr_model

// ===== verification/cmmac_properties.sv
`timescale 1ns/1ps
// ----
// Access policy checks
// ----
module cmmac_properties (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic excEntry,
	input wire logic retiExec,
	input wire logic fetchValid,
	input wire logic [15:0] fetchAddr,
	input wire logic callValid,
	input wire logic [15:0] callTarget,
	input wire logic sfrRd,
	input wire logic sfrWr,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	input wire logic sfrAck,
	input wire logic sfrDenied,
	input wire logic extSfrWr,
	input wire logic memReq,
	input wire cmmac_pkg::cmmac_space_type memSpace,
	input wire logic [15:0] memAddr,
	input wire logic memWr,
	input wire logic memGrant,
	input wire cmmac_pkg::cmmac_mode_type cpuMode,
	input wire logic [15:0] segTablePtr,
	input wire logic segActive
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	wire user = cpuMode == cmmac_pkg::MODE_USER;
	wire quiet = !excEntry && !retiExec && !fetchValid && !callValid;
	wire lo = sfrAddr == cmmac_pkg::SEG_PTR_LO_ADDR;
	wire segReg = lo || sfrAddr == cmmac_pkg::SEG_PTR_HI_ADDR;
	wire ram = memSpace == cmmac_pkg::SPACE_RAM;
	sequence entryEv;
		excEntry || (callValid
		&& callTarget == cmmac_pkg::SPECIAL_CALL_ADDR)
		|| (fetchValid && (fetchAddr == cmmac_pkg::SYSCALL_VEC_ADDR
		|| fetchAddr == cmmac_pkg::CONFIG_VEC_ADDR));
	endsequence
	sequence denyAns;
		sfrAck && sfrDenied && sfrRdata == 8'h00;
	endsequence
	entry_to_system_a: assert property (
		entryEv |=> cpuMode == cmmac_pkg::MODE_SYSTEM)
		else $error("Entry event left mode unchanged");
	ack_follows_a: assert property (
		(sfrRd || sfrWr) |=> sfrAck)
		else $error("No ack after register access");
	denied_zero_a: assert property (sfrDenied |-> sfrRdata == 8'h00)
		else $error("Denied read gave data");
	user_seg_a: assert property (
		(sfrRd || sfrWr) && segReg && user |=> denyAns)
		else $error("User reached segment registers");
	user_ptr_a: assert property (
		sfrWr && segReg && user |=> $stable(segTablePtr))
		else $error("User write moved table pointer");
	sys_ptr_a: assert property (
		sfrWr && lo && cpuMode == cmmac_pkg::MODE_SYSTEM
		|=> segTablePtr[7:0] == $past(sfrWdata))
		else $error("System write to pointer lost");
	program_status_word_high_user_a: assert property (
		sfrWr && sfrAddr == cmmac_pkg::PROGRAM_STATUS_WORD_HIGH_ADDR && user && quiet
		|=> $stable(cpuMode))
		else $error("User changed its own mode");
	seg_active_a: assert property (
		segActive == (segTablePtr != 16'h0000))
		else $error("Segment enable disagrees with pointer");
	ext_granted_a: assert property (extSfrWr |=> !sfrDenied)
		else $error("Outside write strobe on denied access");
	rom_write_a: assert property (
		memWr && memSpace == cmmac_pkg::SPACE_ROM |-> !memGrant)
		else $error("ROM write granted");
	sys_isolate_a: assert property (
		cpuMode == cmmac_pkg::MODE_SYSTEM && ram
		&& memAddr < cmmac_pkg::CLOS_RAM_LIMIT |-> !memGrant)
		else $error("System reached contactless RAM");
	user_noseg_a: assert property (user && !segActive |-> !memGrant)
		else $error("User access without segments");
	grant_req_a: assert property (memGrant |-> memReq)
		else $error("Grant without request");
endmodule // cmmac_properties

bind cmmac_top cmmac_properties chk (.ref_clk, .reset, .excEntry,
	.retiExec, .fetchValid, .fetchAddr, .callValid, .callTarget, .sfrRd,
	.sfrWr, .sfrAddr, .sfrWdata, .sfrRdata, .sfrAck, .sfrDenied,
	.extSfrWr, .memReq, .memSpace, .memAddr, .memWr, .memGrant,
	.cpuMode, .segTablePtr, .segActive);

// ===== verification/tb.sv
`timescale 1ns/1ps
// ----
// Bench
// ----
module tb;
	localparam cmmac_pkg::cmmac_space_type RAM = cmmac_pkg::SPACE_RAM;
	localparam cmmac_pkg::cmmac_space_type ROM = cmmac_pkg::SPACE_ROM;
	localparam cmmac_pkg::cmmac_space_type EE = cmmac_pkg::SPACE_EE;
	localparam cmmac_pkg::cmmac_mode_type SYS = cmmac_pkg::MODE_SYSTEM;
	localparam cmmac_pkg::cmmac_mode_type USR = cmmac_pkg::MODE_USER;
	localparam cmmac_pkg::cmmac_mode_type CLS = cmmac_pkg::MODE_CLOS;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic excEntry, retiExec, fetchValid, callValid, sfrRd, sfrWr;
	logic [15:0] fetchAddr, callTarget, memAddr, segTablePtr;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata, extSfrRdata;
	logic sfrAck, sfrDenied, extSfrRd, extSfrWr, fwHwRdOk, fwHwWrOk;
	logic segRdOk, segWrOk, segExOk, segSfrOk, memReq, memRd, memWr;
	logic memExec, memGrant, segActive;
	cmmac_pkg::cmmac_mode_type cpuMode;
	cmmac_pkg::cmmac_space_type memSpace;
	int fail_count = 0;
	int n_checks = 0;
	cmmac_top dut (.ref_clk, .reset, .excEntry, .retiExec, .fetchValid,
		.fetchAddr, .callValid, .callTarget, .sfrRd, .sfrWr, .sfrAddr,
		.sfrWdata, .sfrRdata, .sfrAck, .sfrDenied, .extSfrRd, .extSfrWr,
		.extSfrRdata, .fwHwRdOk, .fwHwWrOk, .segRdOk, .segWrOk, .segExOk,
		.segSfrOk, .memReq, .memSpace, .memAddr, .memRd, .memWr, .memExec,
		.memGrant, .cpuMode, .segTablePtr, .segActive);
	cmmac_sfr_model partner (.ref_clk, .extSfrRd, .sfrAddr, .extSfrRdata);
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic sfr(input logic w, input logic [7:0] a, d, er,
		input logic ed);
		@(negedge ref_clk);
		sfrWr = w;
		sfrRd = !w;
		sfrAddr = a;
		sfrWdata = d;
		@(negedge ref_clk);
		sfrWr = 1'b0;
		sfrRd = 1'b0;
		chk(16'(sfrAck), 16'h0001);
		chk(16'(sfrRdata), 16'(er));
		chk(16'(sfrDenied), 16'(ed));
	endtask
	// Kinds: 0 exception, 1 fetch, 2 call, 3 return
	task automatic ev(input int k, input logic [15:0] a,
		input cmmac_pkg::cmmac_mode_type m);
		@(negedge ref_clk);
		excEntry = k == 0;
		fetchValid = k == 1;
		callValid = k == 2;
		retiExec = k == 3;
		fetchAddr = a;
		callTarget = a;
		@(negedge ref_clk);
		{excEntry, fetchValid, callValid, retiExec} = 4'h0;
		chk(16'(cpuMode), 16'(m));
	endtask
	task automatic mem(input cmmac_pkg::cmmac_space_type s,
		input logic [15:0] a, input logic [2:0] rwx, input logic g);
		@(negedge ref_clk);
		memReq = 1'b1;
		memSpace = s;
		memAddr = a;
		{memRd, memWr, memExec} = rwx;
		#1;
		chk(16'(memGrant), 16'(g));
	endtask
	initial begin
		{excEntry, retiExec, fetchValid, callValid, sfrRd, sfrWr} = 6'h00;
		{fetchAddr, callTarget, memAddr, sfrAddr, sfrWdata} = 64'h0;
		{fwHwRdOk, fwHwWrOk, segRdOk, segWrOk, segExOk} = 5'h00;
		{segSfrOk, memReq, memRd, memWr, memExec} = 5'h00;
		memSpace = RAM;
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		chk(16'(cpuMode), 16'(SYS));
		chk(segTablePtr, 16'h0000);
		chk(16'(segActive), 16'h0000);
		$display("test reset done");
		sfr(1'b1, 8'h90, 8'h12, 8'h00, 1'b0);
		sfr(1'b1, 8'h91, 8'h34, 8'h00, 1'b0);
		sfr(1'b0, 8'h90, 8'h00, 8'h12, 1'b0);
		chk(segTablePtr, 16'h3412);
		chk(16'(segActive), 16'h0001);
		sfr(1'b1, 8'h92, 8'h00, 8'h00, 1'b0);
		sfr(1'b1, 8'h93, 8'h04, 8'h00, 1'b0);
		sfr(1'b1, 8'h94, 8'h10, 8'h00, 1'b0);
		sfr(1'b0, 8'h94, 8'h00, 8'h10, 1'b0);
		sfr(1'b0, 8'h98, 8'h00, 8'h00, 1'b1);
		sfr(1'b1, 8'hA0, 8'h33, 8'h00, 1'b0);
		mem(RAM, 16'h0400, 3'h4, 1'b1);
		mem(RAM, 16'h0100, 3'h4, 1'b0);
		mem(ROM, 16'h2000, 3'h2, 1'b0);
		$display("test system done");
		sfr(1'b1, 8'h95, 8'h02, 8'h00, 1'b0);
		chk(16'(cpuMode), 16'(CLS));
		mem(RAM, 16'h0100, 3'h4, 1'b1);
		mem(RAM, 16'h0404, 3'h2, 1'b1);
		mem(RAM, 16'h0410, 3'h4, 1'b0);
		mem(ROM, 16'h2000, 3'h4, 1'b0);
		sfr(1'b1, 8'h90, 8'hFF, 8'h00, 1'b1);
		sfr(1'b1, 8'h94, 8'hFF, 8'h00, 1'b1);
		sfr(1'b0, 8'hA0, 8'h00, 8'h00, 1'b1);
		fwHwRdOk = 1'b1;
		sfr(1'b0, 8'hA0, 8'h00, 8'hFA, 1'b0);
		fwHwRdOk = 1'b0;
		sfr(1'b1, 8'hA0, 8'h11, 8'h00, 1'b1);
		fwHwWrOk = 1'b1;
		sfr(1'b1, 8'hA0, 8'h11, 8'h00, 1'b0);
		fwHwWrOk = 1'b0;
		sfr(1'b1, 8'h95, 8'h03, 8'h00, 1'b1);
		chk(16'(cpuMode), 16'(CLS));
		ev(1, cmmac_pkg::SYSCALL_VEC_ADDR, SYS);
		ev(3, 16'h0000, CLS);
		ev(1, cmmac_pkg::CONFIG_VEC_ADDR, SYS);
		$display("test contactless done");
		sfr(1'b1, 8'h95, 8'hA4, 8'h00, 1'b0);
		chk(16'(cpuMode), 16'(USR));
		sfr(1'b1, 8'h90, 8'h55, 8'h00, 1'b1);
		chk(segTablePtr, 16'h3412);
		sfr(1'b0, 8'h91, 8'h00, 8'h00, 1'b1);
		sfr(1'b0, 8'h95, 8'h00, 8'hA4, 1'b0);
		sfr(1'b1, 8'h95, 8'h03, 8'h00, 1'b1);
		chk(16'(cpuMode), 16'(USR));
		segSfrOk = 1'b1;
		sfr(1'b0, 8'hA0, 8'h00, 8'hFA, 1'b0);
		segSfrOk = 1'b0;
		sfr(1'b0, 8'hA1, 8'h00, 8'h00, 1'b1);
		segRdOk = 1'b1;
		mem(RAM, 16'h0400, 3'h4, 1'b1);
		segRdOk = 1'b0;
		mem(RAM, 16'h0400, 3'h4, 1'b0);
		segWrOk = 1'b1;
		mem(EE, 16'h0900, 3'h2, 1'b1);
		mem(EE, 16'h0900, 3'h1, 1'b0);
		segExOk = 1'b1;
		mem(EE, 16'h0900, 3'h1, 1'b1);
		sfr(1'b1, 8'hA1, 8'h77, 8'h00, 1'b1);
		$display("test user done");
		for (int k = 0; k < 3; k++) begin
			ev(k, k == 1 ? cmmac_pkg::SYSCALL_VEC_ADDR
				: cmmac_pkg::SPECIAL_CALL_ADDR, SYS);
			ev(3, 16'h0000, USR);
		end
		ev(2, 16'h00F1, USR);
		$display("test mode events done");
		// Reset in mid-run must restore restrictive state
		reset = 1'b1;
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		chk(segTablePtr, 16'h0000);
		chk(16'(cpuMode), 16'(SYS));
		sfr(1'b1, 8'h95, 8'h04, 8'h00, 1'b0);
		segRdOk = 1'b1;
		mem(RAM, 16'h0400, 3'h4, 1'b0);
		$display("test second reset done");
		wrap_up();
	end
	// Tests need about 100 cycles; allow thirty times that
	initial begin
		#24000;
		fail_count++;
		wrap_up();
	end
endmodule // tb
